// >>> hw/aiac_pkg.sv
// Package holding the constants, field positions and carrier types of the
// analog input acquisition controller.
// Assumes one 10 MHz system clock; imported by the pacer and top-level design files of the block.
package aiac_pkg;

  // ==========================================================================
  // clock and base-frequency timing
  localparam int unsigned SYS_CLK_HZ = 10_000_000;
  localparam int unsigned BASE_UNIT_HZ = 62_500;
  localparam int unsigned BASE_DEFAULT_HZ = 20_000_000;
  localparam int unsigned BASE_TOP_HZ = 8_000_000;
  // phase accumulator wraps once per system clock's worth of base units
  localparam logic [8:0] ACC_MOD = 9'(SYS_CLK_HZ / BASE_UNIT_HZ);
  localparam logic [8:0] STEP_DEFAULT = 9'(BASE_DEFAULT_HZ / BASE_UNIT_HZ);
  localparam logic [8:0] STEP_TOP = 9'(BASE_TOP_HZ / BASE_UNIT_HZ);
  localparam logic [3:0] BASE_CODE_LAST = 4'h7;

  // ==========================================================================
  // register offsets
  localparam logic [4:0] OFS_POLL_CFG = 5'h00;
  localparam logic [4:0] OFS_TRIG_DATA = 5'h04;
  localparam logic [4:0] OFS_RATE = 5'h08;
  localparam logic [4:0] OFS_SCAN_CNT = 5'h0C;
  localparam logic [4:0] OFS_PCFG_STAT = 5'h10;
  localparam logic [4:0] OFS_BASE = 5'h14;

  // ==========================================================================
  // field positions
  localparam int FLUSH_BIT = 15;
  localparam int SLOT_LSB = 10;
  localparam int SLOT_MSB = 14;
  localparam int CK_LSB = 8;
  localparam int CK_MSB = 11;
  localparam int NCH_LSB = 3;
  localparam int NCH_MSB = 7;
  localparam int MODE_MSB = 2;
  localparam int ST_FULL_N = 15;
  localparam int ST_HALF_N = 14;
  localparam int ST_EMPTY_N = 13;
  localparam int ST_BUSY = 12;
  localparam int ST_STRAP = 11;
  localparam logic [15:0] BASE_MASK = 16'h8FFF;

  // ==========================================================================
  // reset values and limits
  localparam logic [7:0] POLL_CFG_RST = 8'h00;
  localparam logic [15:0] RATE_RST = 16'h0000;
  localparam logic [15:0] SCAN_CNT_RST = 16'h0000;
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [15:0] SCAN_CNT_MAX = 16'h1388;

  // ==========================================================================
  // encodings and sizes
  localparam logic [1:0] GRP_SE_HIGH = 2'h2;
  localparam logic [1:0] GRP_DIFFERENTIAL = 2'h3;
  localparam logic [2:0] MODE_PACER = 3'h1;
  localparam logic [2:0] MODE_PACER_CNT = 3'h2;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_HALF = 8;
  localparam int SCAN_SLOTS = 32;

  // gain, input group and channel index as programmed
  typedef struct packed {
    logic [1:0] gain;
    logic [1:0] group;
    logic [3:0] chan;
  } aiac_cfg_t;

  // decoded selection driven to the converter and multiplexer
  typedef struct packed {
    logic [1:0] gain;
    logic differential;
    logic [4:0] chan;
  } aiac_sel_t;

endpackage : aiac_pkg

// >>> hw/aiac_fifo.sv
// Sample buffer with valid/ready on both sides and a synchronous flush.
// Assumes one clock; a pop on an empty buffer is refused by out_valid_o.
`timescale 1ns/1ps
module aiac_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH+1)-1:0] count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic push;
  logic pop;

  // ==========================================================================
  // handshake
  assign in_ready_o = (count_r != CW'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;   // empty read leaves pointers alone
  assign out_data_o = mem_r[rd_ptr_r];
  assign count_o = count_r;

  // pointers and fill level; flush empties the buffer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (flush_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
      if (pop) rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
      count_r <= CW'(count_r + CW'(push) - CW'(pop));
    end
  end

  // storage
  always_ff @(posedge clk_i) begin
    if (push) mem_r[wr_ptr_r] <= in_data_i;
  end

endmodule : aiac_fifo

// >>> hw/aiac_pacer.sv
// Pacer: derives the selected base frequency from the system clock by a
// phase accumulator and issues one trigger per divisor base periods.
// Assumes a 10 MHz clock; base rates above it are averaged over cycles.
`timescale 1ns/1ps
module aiac_pacer
  import aiac_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic base_default_i,
  input wire logic [3:0] base_code_i,
  input wire logic [15:0] divisor_i,
  output logic trig_o
);
  logic [8:0] step;
  logic [9:0] sum;
  logic [1:0] ticks;
  logic [8:0] acc_r;
  logic [8:0] acc_nxt;
  logic [16:0] cnt_r;
  logic [16:0] csum;
  logic [16:0] crem;
  logic hit;

  // ==========================================================================
  // base tick generation, halving per code step
  assign step = base_default_i ? STEP_DEFAULT :
                (base_code_i > BASE_CODE_LAST) ? (STEP_TOP >> BASE_CODE_LAST) :
                (STEP_TOP >> base_code_i);
  assign sum = {1'b0, acc_r} + {1'b0, step};
  assign ticks = (sum >= {ACC_MOD, 1'b0}) ? 2'h2 : (sum >= {1'b0, ACC_MOD}) ? 2'h1 : 2'h0;
  assign acc_nxt = 9'(sum - 10'(ticks) * {1'b0, ACC_MOD});

  // divisor counting in base periods
  assign csum = cnt_r + 17'(ticks);
  assign hit = (divisor_i != '0) && (csum >= {1'b0, divisor_i});
  assign crem = csum - {1'b0, divisor_i};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_r <= '0;
      cnt_r <= '0;
      trig_o <= 1'b0;
    end else if (!run_i) begin
      acc_r <= '0;
      cnt_r <= '0;
      trig_o <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      // a rate above the clock saturates at one trigger a cycle
      cnt_r <= hit ? ((crem >= {1'b0, divisor_i}) ? '0 : crem) : csum;
      trig_o <= hit;
    end
  end

endmodule : aiac_pacer

// >>> hw/aiac_top.sv
// Analog input acquisition controller: register bank, software and pacer
// conversion triggers, scan sequence, sample buffer and status word.
// Assumes a single-word register port and a converter that raises a done
// level with stable data; converter and jumper pins are asynchronous.
//
// Behaviour
// R1 - flush bit in either config empties FIFO
// R2 - bits 7:6 give four gain ranges
// R3 - bits 5:4 pick input group
// R4 - channel is group base plus index
// R5 - polling config reads back as written
// R6 - write 0x04 converts one polling sample
// R7 - read 0x04 pops oldest sample
// R8 - pacer triggers every divisor base periods
// R9 - base clock 20 MHz after reset; any 0x14 write clears it, so pacing never runs at 20 MHz
// R10 - scan sample count readable, at most 5000
// R11 - pacer config fills slot bits 14:10
// R12 - status bits 15:13 active-low FIFO flags
// R13 - status bit 12 shows converter busy
// R14 - status bit 11 shows input-type jumper
// R15 - base code halves from 8 MHz
// R16 - bits 7:3 hold scan slots minus one
// R17 - empty read leaves FIFO untouched
`timescale 1ns/1ps
module aiac_top
  import aiac_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic conv_start_o,
  output aiac_sel_t conv_sel_o,
  input wire logic conv_done_i,
  input wire logic [15:0] conv_data_i,
  input wire logic input_type_jumper_i
);

  // ==========================================================================
  // declarations
  typedef enum logic [1:0] {
    CV_IDLE,
    CV_START,
    CV_WAIT,
    CV_PUSH
  } aiac_cv_t;

  aiac_cv_t cv_r;
  aiac_cv_t cv_nxt;
  aiac_cfg_t poll_cfg_r;
  aiac_cfg_t slot_r [SCAN_SLOTS];
  aiac_sel_t sel_r;
  logic [15:0] rate_r;
  logic [15:0] scan_cnt_r;
  logic [15:0] base_r;
  logic base_default_r;
  logic [15:0] remain_r;
  logic [4:0] scan_idx_r;
  logic [15:0] sample_r;
  logic [15:0] rdata_r;
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] sync3_r;
  logic [1:0] clean_r;
  logic done_seen_r;

  logic wr_poll;
  logic wr_trig;
  logic wr_rate;
  logic wr_scnt;
  logic wr_pcfg;
  logic wr_base;
  logic rd_data;
  logic flush;
  logic [2:0] mode;
  logic [4:0] nch;
  logic pacer_run;
  logic pacer_trig;
  logic sw_start;
  logic pc_start;
  logic done_rise;
  logic strap;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_count;
  logic [15:0] status;
  logic [15:0] scnt_wr;

  // converter selection from a programmed configuration
  function automatic aiac_sel_t cfg_decode(input aiac_cfg_t c);
    aiac_sel_t s;
    s.gain = c.gain;                              // [R2]
    s.differential = (c.group == GRP_DIFFERENTIAL);               // [R3]
    s.chan = {c.group == GRP_SE_HIGH, c.chan};    // [R4]
    return s;
  endfunction : cfg_decode

  // ==========================================================================
  // register decode
  assign wr_poll = reg_wr_i && (reg_addr_i == OFS_POLL_CFG);
  assign wr_trig = reg_wr_i && (reg_addr_i == OFS_TRIG_DATA);
  assign wr_rate = reg_wr_i && (reg_addr_i == OFS_RATE);
  assign wr_scnt = reg_wr_i && (reg_addr_i == OFS_SCAN_CNT);
  assign wr_pcfg = reg_wr_i && (reg_addr_i == OFS_PCFG_STAT);
  assign wr_base = reg_wr_i && (reg_addr_i == OFS_BASE);
  assign rd_data = reg_rd_i && (reg_addr_i == OFS_TRIG_DATA);

  // flush from either configuration word
  assign flush = (wr_poll || wr_pcfg) && reg_wdata_i[FLUSH_BIT];   // [R1]

  // sample count clamped to the supported maximum
  assign scnt_wr = (reg_wdata_i > SCAN_CNT_MAX) ? SCAN_CNT_MAX : reg_wdata_i;   // [R10]

  // scan and base fields
  assign mode = base_r[MODE_MSB:0];
  assign nch = base_r[NCH_MSB:NCH_LSB];   // [R16]

  // ==========================================================================
  // pin synchronisers: conversion done and jumper strap
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
          clean_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= (gi == 0) ? conv_done_i : input_type_jumper_i;
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          // accept a change once the two later stages agree
          if (sync2_r[gi] == sync3_r[gi]) clean_r[gi] <= sync3_r[gi];
        end
      end
    end
  endgenerate

  assign strap = clean_r[1];

  // done counts once per conversion
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) done_seen_r <= 1'b0;
    else done_seen_r <= clean_r[0];
  end

  assign done_rise = clean_r[0] && !done_seen_r;

  // ==========================================================================
  // configuration registers
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      poll_cfg_r <= POLL_CFG_RST;
      rate_r <= RATE_RST;
      scan_cnt_r <= SCAN_CNT_RST;
      base_r <= BASE_RST;
      base_default_r <= 1'b1;                  // [R9]
    end else begin
      if (wr_poll) poll_cfg_r <= reg_wdata_i[7:0];   // [R5]
      if (wr_rate) rate_r <= reg_wdata_i;            // [R8]
      if (wr_scnt) scan_cnt_r <= scnt_wr;            // [R10]
      if (wr_base) base_r <= reg_wdata_i & BASE_MASK;   // [R15]
      if (wr_base) base_default_r <= 1'b0;           // [R9]
    end
  end

  // scan sequence slots, one per index from the pacer config write
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < SCAN_SLOTS; i++) slot_r[i] <= POLL_CFG_RST;
    end else if (wr_pcfg) begin
      slot_r[reg_wdata_i[SLOT_MSB:SLOT_LSB]] <= reg_wdata_i[7:0];   // [R11]
    end
  end

  // ==========================================================================
  // pacer
  assign pacer_run = (mode == MODE_PACER) ||
                     ((mode == MODE_PACER_CNT) && (remain_r != '0));

  aiac_pacer u_pacer (
    .clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .run_i(pacer_run),
    .base_default_i(base_default_r),
    .base_code_i(base_r[CK_MSB:CK_LSB]),
    .divisor_i(rate_r),
    .trig_o(pacer_trig)
  );

  // triggers start only from idle; software wins a tie
  assign sw_start = wr_trig && (cv_r == CV_IDLE);   // [R6]
  assign pc_start = pacer_trig && pacer_run && !wr_trig && (cv_r == CV_IDLE);   // [R8]

  // scan position and remaining sample count
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scan_idx_r <= '0;
      remain_r <= '0;
    end else begin
      if (wr_base) scan_idx_r <= '0;
      else if (pc_start) scan_idx_r <= (scan_idx_r >= nch) ? '0 : 5'(scan_idx_r + 1'b1);   // [R11]
      if (wr_scnt) remain_r <= scnt_wr;
      else if (wr_base) remain_r <= scan_cnt_r;
      else if (pc_start && mode == MODE_PACER_CNT) remain_r <= 16'(remain_r - 1'b1);
    end
  end

  // ==========================================================================
  // conversion sequencer
  always_comb begin
    cv_nxt = cv_r;
    case (cv_r)
      CV_IDLE: begin
        if (sw_start || pc_start) cv_nxt = CV_START;
      end
      CV_START: begin
        cv_nxt = CV_WAIT;
      end
      CV_WAIT: begin
        if (done_rise) cv_nxt = CV_PUSH;
      end
      CV_PUSH: begin
        // a full buffer stalls the sequencer here
        if (fifo_in_ready || flush) cv_nxt = CV_IDLE;
      end
      default: begin
        cv_nxt = CV_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) cv_r <= CV_IDLE;
    else cv_r <= cv_nxt;
  end

  // selection latched at trigger time, sample at done
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_r <= '0;
      sample_r <= '0;
    end else begin
      if (sw_start) sel_r <= cfg_decode(poll_cfg_r);            // [R6]
      else if (pc_start) sel_r <= cfg_decode(slot_r[scan_idx_r]);   // [R11]
      if (cv_r == CV_WAIT && done_rise) sample_r <= conv_data_i;
    end
  end

  assign conv_start_o = (cv_r == CV_START);
  assign conv_sel_o = sel_r;

  // ==========================================================================
  // sample buffer
  aiac_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .flush_i(flush),                                // [R1]
    .in_valid_i(cv_r == CV_PUSH),
    .in_ready_o(fifo_in_ready),
    .in_data_i(sample_r),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(rd_data),                          // [R7] [R17]
    .out_data_o(fifo_out_data),
    .count_o(fifo_count)
  );

  // ==========================================================================
  // status word and read data
  assign status[ST_FULL_N] = (fifo_count != 5'(FIFO_DEPTH));   // [R12]
  assign status[ST_HALF_N] = (fifo_count < 5'(FIFO_HALF));     // [R12]
  assign status[ST_EMPTY_N] = fifo_out_valid;                  // [R12]
  assign status[ST_BUSY] = (cv_r != CV_IDLE);                  // [R13]
  assign status[ST_STRAP] = strap;                             // [R14]
  assign status[10:0] = '0;

  // read word registered on the read strobe
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_POLL_CFG: rdata_r <= {8'h00, poll_cfg_r};   // [R5]
        OFS_TRIG_DATA: rdata_r <= fifo_out_valid ? fifo_out_data : 16'h0000;   // [R7]
        OFS_RATE: rdata_r <= rate_r;
        OFS_SCAN_CNT: rdata_r <= scan_cnt_r;
        OFS_PCFG_STAT: rdata_r <= status;
        OFS_BASE: rdata_r <= base_r;
        default: rdata_r <= 16'h0000;
      endcase
    end
  end

  assign reg_rdata_o = rdata_r;

endmodule : aiac_top

// >>> dv/aiac_top_assertions.sv
// checker of the acquisition controller's port behaviour
// assumes only the ports of aiac_top; bound at the foot of this file
`timescale 1ns/1ps
module aiac_top_assertions
  import aiac_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic conv_start_o,
  input wire aiac_sel_t conv_sel_o,
  input wire logic conv_done_i,
  input wire logic input_type_jumper_i
);
  // ==========
  // helper state
  logic [7:0] cfg_r;
  logic [2:0] mode_r;
  logic [3:0] calm_r;
  logic [2:0] jst_r;
  logic wait_r, done_r, jmp_r;
  wire poff = mode_r != MODE_PACER && mode_r != MODE_PACER_CNT;
  wire wr4 = reg_wr_i && reg_addr_i == OFS_TRIG_DATA;
  wire rd_st = reg_rd_i && reg_addr_i == OFS_PCFG_STAT;
  wire rise = conv_done_i && !done_r;
  // shadows, conversion in flight, quiet and jumper counters
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {cfg_r, mode_r, wait_r, done_r, jmp_r} <= 14'h0000;
      calm_r <= 4'h0;
      jst_r <= 3'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == OFS_POLL_CFG) cfg_r <= reg_wdata_i[7:0];
      if (reg_wr_i && reg_addr_i == OFS_BASE) mode_r <= reg_wdata_i[2:0];
      wait_r <= conv_start_o || (wait_r && !rise);
      done_r <= conv_done_i;
      jmp_r <= input_type_jumper_i;
      calm_r <= rise ? 4'h0 : calm_r + 4'(calm_r != 4'hF);
      jst_r <= (jmp_r != input_type_jumper_i) ? 3'h0 : jst_r + 3'(jst_r != 3'h7);
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  a_sw_start: assert property (
    conv_start_o && poff && $past(poff) |-> $past(wr4))
    else $error("start without a software trigger");
  a_poll_gain: assert property (
    conv_start_o && $past(wr4) |-> conv_sel_o.gain == cfg_r[7:6])
    else $error("gain differs from polling config");
  a_poll_group: assert property (
    conv_start_o && $past(wr4) |-> conv_sel_o.differential == (cfg_r[5:4] == 2'h3))
    else $error("input group differs from polling config");
  a_poll_chan: assert property (
    conv_start_o && $past(wr4) |-> conv_sel_o.chan == {cfg_r[5:4] == 2'h2, cfg_r[3:0]})
    else $error("channel differs from polling config");
  a_poll_back: assert property (
    reg_rd_i && reg_addr_i == OFS_POLL_CFG |=> reg_rdata_o[7:0] == $past(cfg_r))
    else $error("polling config reads back wrong");
  a_rdata_hold: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_busy_flag: assert property (
    rd_st && wait_r |=> reg_rdata_o[ST_BUSY])
    else $error("busy flag low during conversion");
  a_strap_flag: assert property (
    rd_st && jst_r == 3'h7 |=> reg_rdata_o[ST_STRAP] == jmp_r)
    else $error("strap flag differs from jumper");
  a_flush_empty: assert property (
    (reg_wr_i && reg_addr_i == OFS_POLL_CFG && reg_wdata_i[FLUSH_BIT] && !wait_r
    && calm_r > 4'h7) ##1 rd_st |=> !reg_rdata_o[ST_EMPTY_N])
    else $error("buffer not empty after flush");
endmodule : aiac_top_assertions

bind aiac_top aiac_top_assertions i_aiac_top_assertions (.ref_clk_i(ref_clk_i),
  .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .conv_start_o(conv_start_o),
  .conv_sel_o(conv_sel_o), .conv_done_i(conv_done_i),
  .input_type_jumper_i(input_type_jumper_i));

// >>> dv/aiac_conv_model.sv
// converter and multiplexer model: one result per start, done held as a level
// assumes one-cycle start pulses and a selection that holds while converting
`timescale 1ns/1ps
module aiac_conv_model
  import aiac_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire aiac_sel_t sel_i,
  input wire logic slow_i,
  output logic done_o,
  output logic [15:0] data_o
);
  // ==========
  // conversion timing
  logic [7:0] n_r;
  logic [4:0] cnt_r;
  // done drops at start; result stands until the next start
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      n_r <= 8'h00;
      cnt_r <= 5'h00;
      done_o <= 1'b0;
      data_o <= 16'h0000;
    end else if (start_i) begin
      cnt_r <= slow_i ? 5'h14 : 5'h02;
      done_o <= 1'b0;
      data_o <= ~data_o;
    end else if (cnt_r == 5'h01) begin
      cnt_r <= 5'h00;
      done_o <= 1'b1;
      data_o <= {sel_i, n_r};
      n_r <= n_r + 8'h01;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
      data_o <= ~data_o; // invalid data toggles
    end
  end
endmodule : aiac_conv_model

// >>> dv/test_analog_input_acquisition_control.sv
// self-checking bench of the acquisition controller with a converter model
// assumes aiac_top, aiac_conv_model and the bound checker are compiled
`timescale 1ns/1ps
module test_analog_input_acquisition_control
  import aiac_pkg::*;
;
  logic ref_clk_i, nrst_i, reg_wr_i, reg_rd_i, conv_done_i, conv_start_o, jmp, slow, pace;
  logic [4:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, conv_data_i, v, c;
  aiac_sel_t conv_sel_o;
  logic [7:0] pcfg, n8;
  logic [7:0] slot [3];
  logic [4:0] ra [5] = '{OFS_POLL_CFG, OFS_RATE, OFS_SCAN_CNT, OFS_TRIG_DATA, 5'h1C};
  logic [15:0] q [$];
  integer failures, n_tests, seed, k, g, e;
  time t1, t2;
  aiac_top i_aiac_top (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .conv_start_o(conv_start_o), .conv_sel_o(conv_sel_o),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .input_type_jumper_i(jmp));
  aiac_conv_model i_aiac_conv_model (.clk_i(ref_clk_i), .nrst_i(nrst_i),
    .start_i(conv_start_o), .sel_i(conv_sel_o), .slow_i(slow), .done_o(conv_done_i),
    .data_o(conv_data_i));
  // ==========
  // clock, reference model and watchdog
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [15:0] smp(input logic [7:0] cf, input logic [7:0] n);
    smp = {cf[7:6], cf[5:4] == 2'h3, cf[5:4] == 2'h2, cf[3:0], n};
  endfunction : smp
  function automatic logic [15:0] sx(input logic busy);
    integer s;
    s = (q.size() > 16) ? 16 : q.size();
    sx = {s != 16, s < 8, s != 0, busy, jmp, 11'h000};
  endfunction : sx
  // expected sample queued at each conversion start
  always @(negedge ref_clk_i) begin
    if (nrst_i && conv_start_o === 1'b1) begin
      q.push_back(smp(pace ? slot[k] : pcfg, n8));
      n8 = n8 + 8'h01;
      if (pace) k = (k + 1) % 3;
    end
  end
  initial begin
    #6000000;
    failures = failures + 1;
    conclude();
  end
  // ==========
  // register port tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    #5 {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
    if (a == OFS_POLL_CFG) pcfg = d[7:0];
    if (d[FLUSH_BIT] && (a == OFS_POLL_CFG || a == OFS_PCFG_STAT)) q.delete();
    @(posedge ref_clk_i);
    #5 reg_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    {reg_addr_i, reg_rd_i} = {a, 1'b1};
    @(posedge ref_clk_i);
    #5 reg_rd_i = 1'b0;
    @(posedge ref_clk_i);
    #5 d = reg_rdata_o;
  endtask : rd
  task automatic rdq();
    rd(OFS_TRIG_DATA, v);
    chk(v, (q.size() > 0) ? q.pop_front() : 16'h0000);
  endtask : rdq
  task automatic st(input logic b);
    rd(OFS_PCFG_STAT, v);
    chk(v, sx(b));
  endtask : st
  task automatic idle();
    integer m;
    for (m = 0; m < 60; m++) begin
      rd(OFS_PCFG_STAT, v);
      if (v[ST_BUSY] === 1'b0) break;
    end
    chk(16'(m < 60), 16'h0001);
  endtask : idle
  task automatic wst(output time t);
    integer m;
    for (m = 0; m < 200 && conv_start_o !== 1'b1; m++) begin
      @(posedge ref_clk_i);
      #5;
    end
    t = $time;
    @(posedge ref_clk_i);
    #5;
  endtask : wst
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // ==========
  // scenarios
  initial begin
    {reg_wr_i, reg_rd_i, slow, pace, jmp, nrst_i} = 6'h02;
    {reg_addr_i, reg_wdata_i, pcfg, n8} = 37'h0;
    {failures, n_tests, k, seed} = {32'h0, 32'h0, 32'h0, 32'hB984};
    repeat (6) @(posedge ref_clk_i);
    #5 nrst_i = 1'b1;
    repeat (8) @(posedge ref_clk_i);
    #5;
    for (g = 0; g < 5; g++) begin
      rd(ra[g], v);
      chk(v, 16'h0000);
    end
    st(1'b0);
    c = 16'($random(seed));
    wr(OFS_RATE, c);
    rd(OFS_RATE, v);
    chk(v, c);
    c = 16'($random(seed)) % 16'h1389;
    wr(OFS_SCAN_CNT, c);
    rd(OFS_SCAN_CNT, v);
    chk(v, c);
    wr(OFS_SCAN_CNT, 16'hFFFF);
    rd(OFS_SCAN_CNT, v);
    chk(v, SCAN_CNT_MAX);
    $display("test registers done");
    for (g = 0; g < 12; g++) begin
      c = {8'h00, 2'(g / 3), 2'(g % 3 + 1), 4'($random(seed))};
      wr(OFS_POLL_CFG, c);
      rd(OFS_POLL_CFG, v);
      chk(v, c);
      slow = 1'($random(seed));
      e = n8 + 1;
      wr(OFS_TRIG_DATA, 16'($random(seed)));
      wr(OFS_TRIG_DATA, 16'h0000);
      idle();
      chk(16'(n8), 16'(e));
      rdq();
    end
    $display("test polling done");
    slow = 1'b0;
    for (g = 0; g < 17; g++) begin
      wr(OFS_TRIG_DATA, 16'h0000);
      if (g < 16) idle();
      if (g < 16) st(1'b0);
    end
    repeat (40) @(posedge ref_clk_i);
    #5 st(1'b1);
    for (g = 0; g < 18; g++) rdq();
    st(1'b0);
    $display("test buffer done");
    for (g = 0; g < 2; g++) begin
      wr(OFS_TRIG_DATA, 16'h0000);
      idle();
      repeat (10) @(posedge ref_clk_i);
      #5 wr(g ? OFS_PCFG_STAT : OFS_POLL_CFG, 16'h8000);
      st(1'b0);
    end
    $display("test flush done");
    for (g = 0; g < 3; g++) begin
      slot[g] = 8'($random(seed));
      wr(OFS_PCFG_STAT, {1'b1, 5'(g), 2'b00, slot[g]});
    end
    for (g = 0; g < 4; g++) begin
      wr(OFS_RATE, 16'h0028 >> g);
      {pace, k} = {1'b1, 32'h0};
      wr(OFS_BASE, {4'h0, 4'(g), 5'h02, MODE_PACER});
      wst(t1);
      wst(t2);
      chk(16'((t2 - t1) / 100), 16'h0032);
      wr(OFS_BASE, 16'h0000);
      idle();
      pace = 1'b0;
      while (q.size() > 0) rdq();
      st(1'b0);
    end
    // pacer with down counter stops after the programmed count
    wr(OFS_SCAN_CNT, 16'h0004);
    {pace, k} = {1'b1, 32'h0};
    wr(OFS_BASE, {13'h0002, MODE_PACER_CNT});
    repeat (300) @(posedge ref_clk_i);
    #5 idle();
    chk(16'(q.size()), 16'h0004);
    pace = 1'b0;
    while (q.size() > 0) rdq();
    st(1'b0);
    $display("test pacer done");
    jmp = 1'b0;
    repeat (10) @(posedge ref_clk_i);
    #5 st(1'b0);
    $display("test jumper done");
    conclude();
  end
endmodule : test_analog_input_acquisition_control
